// File: rtl/clk_gate_pkg.sv
// shared constants and types for the clock output gating and power control block
package clk_gate_pkg;
    localparam int NUM_OUT   = 19;
    localparam int FAST_LO   = 0;
    localparam int FAST_N    = 7;
    localparam int SLOW_LO   = 7;
    localparam int SLOW_N    = 3;
    localparam int EARLY_IDX = 9;
    localparam int MUX_LO    = 10;
    localparam int MUX_N     = 9;
    localparam int SB_LEN    = 20;
    localparam int STRAP_W   = 4;

    localparam logic [SB_LEN-1:0]  SB_CTRL_RESET = 20'hfffff;
    localparam logic [NUM_OUT-1:0] HOST_OE_RESET = 19'h7ffff;
    localparam logic [NUM_OUT-1:0] SB_MASK_RESET = 19'h00000;

    localparam logic [3:0] REG_HOST_OE = 4'h0;
    localparam logic [3:0] REG_SB_MASK = 4'h1;
    localparam logic [3:0] REG_SB_OUT  = 4'h2;
    localparam logic [3:0] REG_STATUS  = 4'h3;

    localparam int CLK_MHZ        = 100;
    localparam int LATENCY_MAX_US = 5000;
    localparam int RESTART_MAX_US = 300;
    localparam int WAKE_US        = 100;
    localparam int LATENCY_CYCLES = LATENCY_MAX_US * CLK_MHZ;
    localparam int RESTART_CYCLES = RESTART_MAX_US * CLK_MHZ;
    localparam int WAKE_CYCLES    = WAKE_US * CLK_MHZ;
    localparam logic [1:0] PD_SAMPLES = 2'h2;
    localparam logic [2:0] SLOW_CNT_RESET = 3'h0;

    typedef enum logic [3:0] {
        PM_OFF  = 4'b0001,
        PM_WAKE = 4'b0010,
        PM_RUN  = 4'b0100,
        PM_DOWN = 4'b1000
    } pm_state_t;

    typedef struct packed {
        logic [NUM_OUT-1:0] tru;
        logic [NUM_OUT-1:0] cmp;
    } diff_bus_t;

    typedef struct packed {
        logic               pg;
        logic               early_pg;
        logic               mux_sel;
        logic               sb_clk;
        logic               sb_ld_n;
        logic               sb_in;
        logic [FAST_N-1:0]  gate_n;
        logic [STRAP_W-1:0] strap;
    } pins_t;

    typedef struct packed {
        logic [STRAP_W-1:0] strap;
        logic               stable;
        logic               parked;
        logic               pg_seen;
    } status_t;
endpackage

// File: rtl/pin_sync2.sv
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module pin_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,   // system clock
    input  wire logic         rst_n, // synchronous reset
    input  wire logic [W-1:0] d,     // asynchronous pins
    output logic      [W-1:0] q      // synchronised levels
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_ff <= '0;
            q       <= '0;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule // pin_sync2

// File: rtl/sideband_shift.sv
// side-band shift register and output control register
`timescale 1ns/1ps
module sideband_shift (
    input  wire logic                            clk,      // system clock
    input  wire logic                            rst_n,    // synchronous reset
    input  wire logic                            sclk_s,   // synced shift clock
    input  wire logic                            ld_n_s,   // synced shift/load
    input  wire logic                            sin_s,    // synced serial data
    output logic [clk_gate_pkg::SB_LEN-1:0]      ctrl_ff,  // output control register
    output logic                                 sout      // serial data out
);
    logic [clk_gate_pkg::SB_LEN-1:0] shift_ff;
    logic                            sclk_d_ff;
    logic                            ld_n_d_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclk_d_ff <= 1'b0;
            ld_n_d_ff <= 1'b0;
        end else begin
            sclk_d_ff <= sclk_s;
            ld_n_d_ff <= ld_n_s;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shift_ff <= '0;
        end else if (ld_n_s && sclk_s && !sclk_d_ff) begin
            shift_ff <= {shift_ff[clk_gate_pkg::SB_LEN-2:0], sin_s};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_ff <= clk_gate_pkg::SB_CTRL_RESET;
        end else if (!ld_n_s && ld_n_d_ff) begin
            ctrl_ff <= shift_ff;
        end
    end

    assign sout = shift_ff[clk_gate_pkg::SB_LEN-1];

    AST_SB_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
        (!ld_n_s && ld_n_d_ff) |=> ctrl_ff == $past(shift_ff))
        else $error("side-band load did not copy shift register");
endmodule // sideband_shift

// File: rtl/clock_output_gating_power_control.sv
// clock output gating and power-good / power-down control
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module clock_output_gating_power_control #(
    parameter int unsigned WAKE_CYCLES = clk_gate_pkg::WAKE_CYCLES
) (
    input  wire logic                                clk,                        // 100 MHz clock
    input  wire logic                                rst_n,                      // sync reset
    input  wire logic                                power_good_or_down_n,       // pg / pd pin
    input  wire logic                                early_low_freq_power_good,  // early pg
    input  wire logic                                mux_output_freq_select,     // 1 = slow
    input  wire logic [clk_gate_pkg::FAST_N-1:0]     dedicated_output_gate_n,    // gate pins
    input  wire logic [clk_gate_pkg::STRAP_W-1:0]    bus_address_strap,          // address straps
    input  wire logic                                sideband_shift_clock,       // sb clock
    input  wire logic                                sideband_shift_load_n,      // sb shift/load
    input  wire logic                                sideband_serial_in,         // sb data in
    output logic                                     sideband_serial_out,        // sb data out
    input  wire logic [3:0]                          reg_addr,                   // register index
    input  wire logic [31:0]                         reg_wdata,                  // write data
    input  wire logic                                reg_wr,                     // write strobe
    input  wire logic                                reg_rd,                     // read strobe
    output logic      [31:0]                         reg_rdata,                  // read data
    output clk_gate_pkg::diff_bus_t                  clk_out,                    // output pairs
    output logic                                     clocks_stable               // outputs running
);
    localparam int NO = clk_gate_pkg::NUM_OUT;

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisation
    clk_gate_pkg::pins_t     pins_raw;
    clk_gate_pkg::pins_t     pins_s;
    clk_gate_pkg::pm_state_t state_ff;
    logic [clk_gate_pkg::SB_LEN-1:0]  sb_ctrl;
    logic [NO-1:0]                    host_oe_ff;
    logic [NO-1:0]                    sb_mask_ff;
    logic [NO-1:0]                    en_ff;
    logic [NO-1:0]                    want;
    logic [NO-1:0]                    sb_gate;
    logic [NO-1:0]                    phase_vec;
    logic [clk_gate_pkg::STRAP_W-1:0] strap_ff;
    logic [13:0]                      wake_cnt_ff;
    logic [1:0]                       pd_cnt_ff;
    logic [2:0]                       slow_cnt_ff;
    logic                             fast_ph_ff;
    logic                             sel_ff;
    logic                             run;
    logic                             going_down;
    logic                             slow_ph;
    logic [31:0]                      nxt_rdata;
    logic [19:0]                      since_pg_ff;

    // every pin is synchronised, so levels held before power are harmless
    assign pins_raw = '{pg: power_good_or_down_n, early_pg: early_low_freq_power_good,
                        mux_sel: mux_output_freq_select, sb_clk: sideband_shift_clock,
                        sb_ld_n: sideband_shift_load_n, sb_in: sideband_serial_in,
                        gate_n: dedicated_output_gate_n, strap: bus_address_strap};

    pin_sync2 #(
        .W ($bits(clk_gate_pkg::pins_t))
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (pins_raw),
        .q     (pins_s)
    );

    sideband_shift u_sb (
        .clk     (clk),
        .rst_n   (rst_n),
        .sclk_s  (pins_s.sb_clk),
        .ld_n_s  (pins_s.sb_ld_n),
        .sin_s   (pins_s.sb_in),
        .ctrl_ff (sb_ctrl),
        .sout    (sideband_serial_out)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // output phase generation
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fast_ph_ff  <= 1'b0;
            slow_cnt_ff <= clk_gate_pkg::SLOW_CNT_RESET;
        end else begin
            fast_ph_ff  <= !fast_ph_ff;
            slow_cnt_ff <= slow_cnt_ff + 3'h1;
        end
    end

    assign slow_ph = slow_cnt_ff[2];

    // select only moves while both sources are low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sel_ff <= 1'b0;
        end else if (!fast_ph_ff && !slow_ph) begin
            sel_ff <= pins_s.mux_sel;
        end
    end

    always_comb begin
        phase_vec = '0;
        for (int i = 0; i < NO; i++) begin
            if (i < clk_gate_pkg::SLOW_LO) begin
                phase_vec[i] = fast_ph_ff;
            end else if (i < clk_gate_pkg::MUX_LO) begin
                phase_vec[i] = slow_ph;
            end else begin
                phase_vec[i] = sel_ff ? slow_ph : fast_ph_ff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // power state machine
    // a stop is taken only where the fast true leg is about to rise
    assign going_down = (state_ff == clk_gate_pkg::PM_RUN) &&
                        (pd_cnt_ff >= clk_gate_pkg::PD_SAMPLES) && !fast_ph_ff;

    // samples are taken where the complement leg rises
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pd_cnt_ff <= 2'h0;
        end else if (pins_s.pg) begin
            pd_cnt_ff <= 2'h0;
        end else if (fast_ph_ff && pd_cnt_ff < clk_gate_pkg::PD_SAMPLES) begin
            pd_cnt_ff <= pd_cnt_ff + 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff    <= clk_gate_pkg::PM_OFF;
            wake_cnt_ff <= 14'h0;
        end else begin
            case (state_ff)
                clk_gate_pkg::PM_OFF: begin
                    wake_cnt_ff <= 14'h0;
                    if (pins_s.pg) begin
                        state_ff <= clk_gate_pkg::PM_WAKE;
                    end
                end
                clk_gate_pkg::PM_WAKE: begin
                    if (!pins_s.pg) begin
                        state_ff <= clk_gate_pkg::PM_DOWN;
                    end else if (wake_cnt_ff == 14'(WAKE_CYCLES - 1)) begin
                        state_ff <= clk_gate_pkg::PM_RUN;
                    end else begin
                        wake_cnt_ff <= wake_cnt_ff + 14'h1;
                    end
                end
                clk_gate_pkg::PM_RUN: begin
                    if (going_down) begin
                        state_ff <= clk_gate_pkg::PM_DOWN;
                    end
                end
                clk_gate_pkg::PM_DOWN: begin
                    wake_cnt_ff <= 14'h0;
                    if (pins_s.pg) begin
                        state_ff <= clk_gate_pkg::PM_WAKE;
                    end
                end
                default: begin
                    state_ff    <= clk_gate_pkg::PM_OFF;
                    wake_cnt_ff <= 14'h0;
                end
            endcase
        end
    end

    // straps are caught once, on the first power-good only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strap_ff <= '0;
        end else if (state_ff == clk_gate_pkg::PM_OFF && pins_s.pg) begin
            strap_ff <= pins_s.strap;
        end
    end

    assign run = (state_ff == clk_gate_pkg::PM_RUN);
    assign clocks_stable = run;

    ////////////////////////////////////////////////////////////////////////////////
    // enable combination and glitch-free gating
    assign sb_gate = sb_mask_ff | sb_ctrl[NO-1:0];

    always_comb begin
        for (int i = 0; i < NO; i++) begin
            want[i] = run && host_oe_ff[i] && sb_gate[i];
        end
        for (int i = 0; i < clk_gate_pkg::FAST_N; i++) begin
            want[clk_gate_pkg::FAST_LO + i] = want[clk_gate_pkg::FAST_LO + i] &&
                                              !pins_s.gate_n[i];
        end
        if (!pins_s.pg && pins_s.early_pg) begin
            want[clk_gate_pkg::EARLY_IDX] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            en_ff <= '0;
        end else if (going_down) begin
            en_ff <= '0;
        end else begin
            for (int i = 0; i < NO; i++) begin
                if (!phase_vec[i]) begin
                    en_ff[i] <= want[i];
                end
            end
        end
    end

    assign clk_out.tru = en_ff & phase_vec;
    assign clk_out.cmp = en_ff & ~phase_vec;

    ////////////////////////////////////////////////////////////////////////////////
    // register port
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            host_oe_ff <= clk_gate_pkg::HOST_OE_RESET;
            sb_mask_ff <= clk_gate_pkg::SB_MASK_RESET;
        end else if (reg_wr) begin
            if (reg_addr == clk_gate_pkg::REG_HOST_OE) begin
                host_oe_ff <= reg_wdata[NO-1:0];
            end
            if (reg_addr == clk_gate_pkg::REG_SB_MASK) begin
                sb_mask_ff <= reg_wdata[NO-1:0];
            end
        end
    end

    always_comb begin
        nxt_rdata = 32'h0;
        case (reg_addr)
            clk_gate_pkg::REG_HOST_OE: nxt_rdata = {13'h0, host_oe_ff};
            clk_gate_pkg::REG_SB_MASK: nxt_rdata = {13'h0, sb_mask_ff};
            clk_gate_pkg::REG_SB_OUT:  nxt_rdata = {12'h0, sb_ctrl};
            clk_gate_pkg::REG_STATUS: begin
                nxt_rdata = {25'h0, clk_gate_pkg::status_t'{strap: strap_ff, stable: run,
                             parked: state_ff == clk_gate_pkg::PM_DOWN,
                             pg_seen: state_ff != clk_gate_pkg::PM_OFF}};
            end
            default: nxt_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_rd ? nxt_rdata : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    always_ff @(posedge clk) begin
        if (!rst_n || !pins_s.pg || run) begin
            since_pg_ff <= 20'h0;
        end else if (since_pg_ff != 20'hfffff) begin
            since_pg_ff <= since_pg_ff + 20'h1;
        end
    end

    AST_FAST_GATE_PIN: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(clk_out.tru[clk_gate_pkg::FAST_LO]) |-> $past(!pins_s.gate_n[0]))
        else $error("fast output started with its gate pin high");

    AST_MUX_SLOW: assert property (@(posedge clk) disable iff (!rst_n)
        sel_ff && $rose(clk_out.tru[clk_gate_pkg::MUX_LO]) ##1 sel_ff
        |-> clk_out.tru[clk_gate_pkg::MUX_LO])
        else $error("slow-selected mux output had a short high phase");

    AST_FAST_ALL_ENABLES: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(clk_out.tru[clk_gate_pkg::FAST_LO]) |->
        $past(run && host_oe_ff[0] && sb_gate[0]))
        else $error("fast output started without all enables");

    AST_EARLY_SLOW: assert property (@(posedge clk) disable iff (!rst_n)
        !run && $rose(clk_out.tru[clk_gate_pkg::EARLY_IDX])
        |-> $past(pins_s.early_pg))
        else $error("early slow output ran without early power-good");

    AST_STRAP_HELD: assert property (@(posedge clk) disable iff (!rst_n)
        (state_ff != clk_gate_pkg::PM_OFF) && ($past(state_ff) != clk_gate_pkg::PM_OFF)
        |-> $stable(strap_ff))
        else $error("straps changed after power-good");

    AST_PD_PARK: assert property (@(posedge clk) disable iff (!rst_n)
        run && pd_cnt_ff >= clk_gate_pkg::PD_SAMPLES
        |-> ##[1:2] (clk_out.tru == '0 && clk_out.cmp == '0))
        else $error("outputs not parked after two low samples");

    AST_LATENCY: assert property (@(posedge clk) disable iff (!rst_n)
        since_pg_ff < 20'(clk_gate_pkg::LATENCY_CYCLES))
        else $error("clocks not stable within latency limit");

    AST_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
        since_pg_ff < 20'(clk_gate_pkg::RESTART_CYCLES))
        else $error("parked outputs not restarted in time");

    AST_NO_RUNT: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(going_down) |-> ((en_ff ^ $past(en_ff)) & $past(phase_vec)) == '0)
        else $error("enable changed while output clock high");
endmodule // clock_output_gating_power_control

// File: verification/power_sideband_host.sv
// platform power sequencer and side-band enable controller model
`timescale 1ns/1ps
module power_sideband_host (
    input  wire logic clk,                       // system clock
    output logic      power_good_or_down_n,      // pg / pd pin
    output logic      early_low_freq_power_good, // early pg pin
    output logic      sideband_shift_clock,      // sb clock pin
    output logic      sideband_shift_load_n,     // sb shift/load pin
    output logic      sideband_serial_in         // sb data pin
);
    // pins already at valid levels before power-good
    initial begin
        power_good_or_down_n      = 1'b0;
        early_low_freq_power_good = 1'b0;
        sideband_shift_clock      = 1'b0;
        sideband_shift_load_n     = 1'b0;
        sideband_serial_in        = 1'b0;
    end

    // pin raised or dropped while the reference clock keeps running
    task automatic set_power(input logic pg, input logic early);
        @(posedge clk);
        power_good_or_down_n      <= pg;
        early_low_freq_power_good <= early;
    endtask

    // twenty bits, msb first, clock parked low before the load edge
    task automatic shift_word(input logic [19:0] w);
        @(posedge clk);
        sideband_shift_load_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 19; i >= 0; i--) begin
            sideband_serial_in <= w[i];
            repeat (3) @(posedge clk);
            sideband_shift_clock <= 1'b1;
            repeat (3) @(posedge clk);
            sideband_shift_clock <= 1'b0;
            repeat (3) @(posedge clk);
        end
        sideband_serial_in    <= 1'b0;
        sideband_shift_load_n <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
endmodule // power_sideband_host

// File: verification/clock_output_gating_power_control_test.sv
// self-checking testbench for the clock output gating and power control block
`timescale 1ns/1ps
module clock_output_gating_power_control_test;
    logic                    clk;
    logic                    rst_n;
    logic                    mux_sel;
    logic [6:0]              gate_n;
    logic [3:0]              strap;
    logic [3:0]              addr;
    logic [31:0]             wdata;
    logic                    wr;
    logic                    rd;
    logic [31:0]             rdata;
    logic [31:0]             d;
    logic                    pg;
    logic                    epg;
    logic                    sclk;
    logic                    ld_n;
    logic                    sin;
    logic                    sout;
    logic                    stable;
    clk_gate_pkg::diff_bus_t clk_out;
    logic [18:0]             host_oe;
    logic [18:0]             sb_mask;
    logic [19:0]             sb_ctrl;
    int                      check_count;
    int                      fail_count;

    power_sideband_host host (.clk(clk), .power_good_or_down_n(pg),
        .early_low_freq_power_good(epg), .sideband_shift_clock(sclk),
        .sideband_shift_load_n(ld_n), .sideband_serial_in(sin));

    clock_output_gating_power_control #(.WAKE_CYCLES(20)) dut (
        .clk(clk), .rst_n(rst_n), .power_good_or_down_n(pg),
        .early_low_freq_power_good(epg), .mux_output_freq_select(mux_sel),
        .dedicated_output_gate_n(gate_n), .bus_address_strap(strap),
        .sideband_shift_clock(sclk), .sideband_shift_load_n(ld_n),
        .sideband_serial_in(sin), .sideband_serial_out(sout), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
        .clk_out(clk_out), .clocks_stable(stable));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic wait_stable();
        int n;
        n = 0;
        while (stable !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("clocks_stable", {31'h0, stable}, 32'h1);
    endtask

    // outputs that should run: host enable and (side-band mask or control) and gate pin; only the early output when unpowered
    function automatic logic [18:0] exp_act(input logic p, input logic e);
        logic [18:0] r;
        r = host_oe & (sb_mask | sb_ctrl[18:0]);
        r[6:0] = r[6:0] & ~gate_n;
        if (!p) begin
            r = {9'h0, e, 9'h0};
        end
        return r;
    endfunction

    // collects which outputs toggled over 16 cycles after settling
    task automatic observe(input string what, input logic p, input logic e);
        logic [18:0] act;
        logic [18:0] actc;
        logic [18:0] both;
        logic [18:0] expv;
        logic        prev;
        int          rises;
        repeat (12) @(posedge clk);
        #1;
        expv  = exp_act(p, e);
        act   = 19'h0;
        actc  = 19'h0;
        both  = 19'h0;
        rises = 0;
        prev  = clk_out.tru[10];
        repeat (16) begin
            @(posedge clk);
            #1;
            act  = act | clk_out.tru;
            actc = actc | clk_out.cmp;
            both = both | (clk_out.tru & clk_out.cmp);
            if (clk_out.tru[10] && !prev) rises++;
            prev = clk_out.tru[10];
        end
        check(what, {13'h0, act}, {13'h0, expv});
        check("cmp legs", {13'h0, actc}, {13'h0, expv});
        check("legs apart", {13'h0, both}, 32'h0);
        if (expv[10]) check("mux rate", {31'h0, rises > 4}, {31'h0, !mux_sel});
        $display("test %s done", what);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n   = 1'b0;
        mux_sel = 1'b0;
        gate_n  = 7'h0a;
        strap   = 4'ha;
        addr    = 4'h0;
        wdata   = 32'h0;
        wr      = 1'b0;
        rd      = 1'b0;
        host_oe = clk_gate_pkg::HOST_OE_RESET;
        sb_mask = clk_gate_pkg::SB_MASK_RESET;
        sb_ctrl = clk_gate_pkg::SB_CTRL_RESET;
        check_count = 0;
        fail_count  = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        reg_read(clk_gate_pkg::REG_HOST_OE, d);
        check("host oe reset", d, {13'h0, host_oe});
        reg_read(clk_gate_pkg::REG_SB_MASK, d);
        check("mask reset", d, 32'h0);
        reg_write(clk_gate_pkg::REG_SB_OUT, 32'h0);
        reg_read(clk_gate_pkg::REG_SB_OUT, d);
        check("sb out ro", d, {12'h0, sb_ctrl});
        reg_read(clk_gate_pkg::REG_STATUS, d);
        check("status off", d, 32'h0);
        reg_read(4'h7, d);
        check("unmapped", d, 32'h0);
        observe("off", 1'b0, 1'b0);
        host.set_power(1'b1, 1'b0);
        wait_stable();
        reg_read(clk_gate_pkg::REG_STATUS, d);
        check("status run", d, {25'h0, 4'ha, 3'b101});
        strap <= 4'h3;
        observe("run", 1'b1, 1'b0);
        reg_read(clk_gate_pkg::REG_STATUS, d);
        check("strap held", d, {25'h0, 4'ha, 3'b101});
        gate_n  <= 7'h0b;
        host_oe = 19'h7efff;
        reg_write(clk_gate_pkg::REG_HOST_OE, {13'h0, host_oe});
        observe("host oe", 1'b1, 1'b0);
        sb_mask = 19'h08000;
        reg_write(clk_gate_pkg::REG_SB_MASK, {13'h0, sb_mask});
        sb_ctrl = 20'hf7eff;
        host.shift_word(sb_ctrl);
        reg_read(clk_gate_pkg::REG_SB_OUT, d);
        check("sb out load", d, {12'h0, sb_ctrl});
        check("serial out", {31'h0, sout}, {31'h0, sb_ctrl[19]});
        observe("side band", 1'b1, 1'b0);
        mux_sel <= 1'b1;
        observe("mux slow", 1'b1, 1'b0);
        mux_sel <= 1'b0;
        observe("mux fast", 1'b1, 1'b0);
        host.set_power(1'b0, 1'b1);
        observe("down", 1'b0, 1'b1);
        check("stable low", {31'h0, stable}, 32'h0);
        reg_read(clk_gate_pkg::REG_STATUS, d);
        check("parked", {29'h0, d[2:0]}, 32'h3);
        host.set_power(1'b1, 1'b0);
        wait_stable();
        observe("restart", 1'b1, 1'b0);
        reg_read(clk_gate_pkg::REG_STATUS, d);
        check("status back", d, {25'h0, 4'ha, 3'b101});
        final_report();
    end

    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        final_report();
    end
endmodule // clock_output_gating_power_control_test
